// file: pkg/sfcc_pkg.sv
// Constants, register map and carrier types for sync frame clock correction
// Assumes a single 20 MHz clock and a classic Wishbone register slave
//
// Overview of operation
// RULE1: Report channel coding errors as four-bit codes
// RULE2: Coding error capture safe across clock ratios; code loses an error when toggle_in flips twice between clk_in edges
// RULE3: Record deviation between reference and action point
// RULE4: Boundary non-sync value never reaches next sync
// RULE5: Store deviation of the valid sync frame
// RULE6: Own sync frame counted; overflow above limit
// RULE7: Odd offset uses only even-cycle identifiers; code admits any id while even_n is below sync_node_limit
// RULE8: Identifier lists hold used frames, up to limit
// RULE9: Opposite signs across channels pick the negative
// RULE10: Per-channel delay compensation before comparing
// RULE11: Fault-tolerant midpoint yields correction terms; code gives the rate term as rate_acc shifted right by 2
// RULE12: Cluster keeps sync senders within limit
package sfcc_pkg;

    // ==========================================================
    // Sizes
    localparam int DEV_W = 16;
    localparam int ID_W = 11;
    localparam int MAX_SYNC = 15;
    localparam int LIST_AW = 4;

    // ==========================================================
    // Register word offsets (byte addresses)
    localparam logic [7:0] TEST_ONE_OFS = 8'h00;
    localparam logic [7:0] ERR_FLAG_OFS = 8'h04;
    localparam logic [7:0] TIMING_TWO_OFS = 8'h08;
    localparam logic [7:0] TIMING_FIVE_OFS = 8'h0c;
    localparam logic [7:0] CORR_OFS = 8'h10;
    localparam logic [7:0] COUNT_OFS = 8'h14;
    localparam logic [7:0] EVEN_LIST_OFS = 8'h40;
    localparam logic [7:0] ODD_LIST_OFS = 8'h80;
    localparam logic [7:0] LIST_SPAN = 8'h40;

    // ==========================================================
    // Field positions and reset values
    localparam int CODE_W = 4;
    localparam int CODE_B_LSB = 4;
    localparam int DCB_LSB = 16;
    localparam logic [3:0] NO_CODING_ERROR = 4'h0;
    localparam logic [3:0] SNM_RESET = 4'hf;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic sync;
        logic [ID_W-1:0] id;
        logic signed [DEV_W-1:0] dev;
    } sfcc_meas_type;

    typedef enum logic [2:0] {
        SFCC_IDLE = 3'h1,
        SFCC_SEL = 3'h2,
        SFCC_DONE = 3'h4
    } sfcc_mid_state_type;

    function automatic logic signed [DEV_W-1:0] sfcc_comp(
        input logic signed [DEV_W-1:0] dev,
        input logic [DEV_W-1:0] comp
    );
        sfcc_comp = dev - $signed(comp);
    endfunction

endpackage

// file: hdl/sfcc_list_mem.sv
// Identifier list memory for even and odd sync lists
// Assumes one clock; read data registered
`timescale 1ns/1ps
module sfcc_list_mem #(
    parameter int AW = 4,
    parameter int DW = 11
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule

// file: hdl/sfcc_code_sync.sv
// Carries a coding error code from the sample clock side
// Assumes code_in valid with a toggle that marks each new error
`timescale 1ns/1ps
module sfcc_code_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic toggle_in,
    input wire logic [3:0] code_in,
    output logic [3:0] code_out,
    output logic event_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [3:0] code;
        logic ev;
    } sfcc_sync_state_type;
    sfcc_sync_state_type st_reg;
    sfcc_sync_state_type st_next;

    // ==========================================================
    // Toggle crossing: an edge is lost if toggle_in flips twice between clk_in edges (see RULE2)
    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = toggle_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.ev = st_reg.s2 ^ st_reg.s3;
        if (st_reg.s2 ^ st_reg.s3)
        begin
            st_next.code = code_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign code_out = st_reg.code;
    assign event_out = st_reg.ev;
endmodule

// file: hdl/sfcc_top.sv
// Sync frame measurement, counting and correction term selection
// Assumes measurement events come in on clk_in; Wishbone classic slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sfcc_top #(
    parameter int MAX_SYNC = sfcc_pkg::MAX_SYNC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic chan_a_coding_error_code_toggle_in,
    input wire logic [3:0] chan_a_coding_error_code_code_in,
    input wire logic chan_b_coding_error_code_toggle_in,
    input wire logic [3:0] chan_b_coding_error_code_code_in,
    input wire logic cycle_start_in,
    input wire logic cycle_odd_in,
    input wire logic slot_boundary_in,
    input wire logic sync_node_in,
    input wire logic own_sync_tx_in,
    input wire sfcc_pkg::sfcc_meas_type meas_a_in,
    input wire sfcc_pkg::sfcc_meas_type meas_b_in,
    output logic signed [15:0] offset_corr_out,
    output logic signed [15:0] rate_corr_out,
    output logic corr_valid_out
);
    localparam int DW = sfcc_pkg::DEV_W;
    localparam int IW = sfcc_pkg::ID_W;
    localparam int AW = sfcc_pkg::LIST_AW;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic sync_frame_overflow_flag;
        logic [3:0] sync_node_limit;
        logic [DW-1:0] dca;
        logic [DW-1:0] dcb;
        logic [4:0] count;
        logic [AW:0] even_n;
        logic [AW:0] odd_n;
        logic signed [DW-1:0] pend_dev;
        logic pend_ok;
        logic signed [DW-1:0] min_dev;
        logic signed [DW-1:0] max_dev;
        logic signed [DW-1:0] min2_dev;
        logic signed [DW-1:0] max2_dev;
        logic signed [DW-1:0] rate_acc;
        logic signed [DW-1:0] off;
        logic signed [DW-1:0] rate;
        logic corr_v;
        sfcc_pkg::sfcc_mid_state_type mst;
    } sfcc_state_type;

    sfcc_state_type st_reg;
    sfcc_state_type st_next;
    logic [3:0] code_a;
    logic [3:0] code_b;
    logic [IW-1:0] even_rd;
    logic [IW-1:0] odd_rd;
    logic list_we_even;
    logic list_we_odd;
    logic [AW-1:0] list_waddr;
    logic [AW-1:0] list_raddr;
    logic [AW-1:0] match_idx;
    logic in_even;
    logic signed [DW-1:0] dev_a;
    logic signed [DW-1:0] dev_b;
    logic signed [DW-1:0] chosen;
    logic have_frame;
    logic [IW-1:0] frame_id;
    logic wb_req;

    // ==========================================================
    // Coding error crossings (see RULE1) (see RULE2)
    sfcc_code_sync u_sync_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .toggle_in(chan_a_coding_error_code_toggle_in),
        .code_in(chan_a_coding_error_code_code_in),
        .code_out(code_a),
        .event_out()
    );
    sfcc_code_sync u_sync_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .toggle_in(chan_b_coding_error_code_toggle_in),
        .code_in(chan_b_coding_error_code_code_in),
        .code_out(code_b),
        .event_out()
    );

    // ==========================================================
    // Identifier lists
    sfcc_list_mem #(.AW(AW), .DW(IW)) u_even (
        .clk_in(clk_in),
        .we_in(list_we_even),
        .waddr_in(list_waddr),
        .wdata_in(frame_id),
        .raddr_in(list_raddr),
        .rdata_out(even_rd)
    );
    sfcc_list_mem #(.AW(AW), .DW(IW)) u_odd (
        .clk_in(clk_in),
        .we_in(list_we_odd),
        .waddr_in(list_waddr),
        .wdata_in(frame_id),
        .raddr_in(list_raddr),
        .rdata_out(odd_rd)
    );

    // Shadow of even ids for a one-cycle membership check
    logic [IW-1:0] even_ids [0:(1<<AW)-1];
    always_ff @(posedge clk_in)
    begin
        if (list_we_even)
        begin
            even_ids[list_waddr] <= frame_id;
        end
    end

    // ==========================================================
    // Channel selection after compensation (see RULE10)
    always_comb
    begin
        dev_a = sfcc_pkg::sfcc_comp(meas_a_in.dev, st_reg.dca);
        dev_b = sfcc_pkg::sfcc_comp(meas_b_in.dev, st_reg.dcb);
        have_frame = (meas_a_in.valid && meas_a_in.sync)
            || (meas_b_in.valid && meas_b_in.sync);
        frame_id = (meas_a_in.valid && meas_a_in.sync)
            ? meas_a_in.id : meas_b_in.id;
        chosen = dev_a;
        if (meas_a_in.valid && meas_a_in.sync
            && meas_b_in.valid && meas_b_in.sync)
        begin
            // Smaller value wins, so a negative one always beats (see RULE9)
            chosen = (dev_b < dev_a) ? dev_b : dev_a;
        end
        else if (meas_b_in.valid && meas_b_in.sync)
        begin
            chosen = dev_b;
        end
    end

    // ==========================================================
    // Even-cycle membership for odd offset set (see RULE7)
    always_comb
    begin
        in_even = 1'b0;
        match_idx = '0;
        for (int i = 0; i < (1 << AW); i++)
        begin
            if (i < int'(st_reg.even_n) && even_ids[i] == frame_id)
            begin
                in_even = 1'b1;
                match_idx = AW'(i);
            end
        end
    end

    assign wb_req = wb_cyc_in && wb_stb_in && !st_reg.ack;
    assign list_raddr = wb_adr_in[AW+1:2];
    assign list_waddr = cycle_odd_in ? st_reg.odd_n[AW-1:0]
        : st_reg.even_n[AW-1:0];
    // Even-id filter applied only once even set reached the limit (see RULE7)
    always_comb
    begin
        list_we_even = 1'b0;
        list_we_odd = 1'b0;
        if (have_frame && st_reg.pend_ok)
        begin
            if (!cycle_odd_in && st_reg.even_n < (AW+1)'(MAX_SYNC))
            begin
                list_we_even = 1'b1; // see RULE8
            end
            else if (cycle_odd_in && st_reg.odd_n < (AW+1)'(MAX_SYNC)
                && (st_reg.even_n < (AW+1)'(st_reg.sync_node_limit) || in_even))
            begin
                list_we_odd = 1'b1; // see RULE8
            end
        end
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        st_next.ack = wb_req;
        st_next.corr_v = 1'b0;
        // Each slot boundary arms this slot; a sync frame off the
        // boundary clears the arm so an old value cannot leak (see RULE4)
        if (slot_boundary_in)
        begin
            st_next.pend_ok = 1'b1;
        end
        // A later valid sync frame overrides any noise value,
        // including at the action point itself (see RULE5)
        if (have_frame && st_reg.pend_ok)
        begin
            st_next.pend_dev = chosen; // see RULE3
            st_next.count = st_reg.count + 5'h1;
            st_next.rate_acc = st_reg.rate_acc + chosen;
            if (list_we_even)
            begin
                st_next.even_n = st_reg.even_n + 1'b1;
            end
            if (list_we_odd)
            begin
                st_next.odd_n = st_reg.odd_n + 1'b1;
                // Midpoint trackers kept for offset set (see RULE11)
                if (chosen < st_reg.min_dev)
                begin
                    st_next.min2_dev = st_reg.min_dev;
                    st_next.min_dev = chosen;
                end
                else if (chosen < st_reg.min2_dev)
                begin
                    st_next.min2_dev = chosen;
                end
                if (chosen > st_reg.max_dev)
                begin
                    st_next.max2_dev = st_reg.max_dev;
                    st_next.max_dev = chosen;
                end
                else if (chosen > st_reg.max2_dev)
                begin
                    st_next.max2_dev = chosen;
                end
            end
        end
        if (have_frame && !slot_boundary_in)
        begin
            st_next.pend_ok = 1'b0;
        end
        if (cycle_start_in)
        begin
            st_next.mst = sfcc_pkg::SFCC_SEL;
            // Own frame counts too (see RULE6)
            if ((st_reg.count + 5'(sync_node_in && own_sync_tx_in))
                > {1'b0, st_reg.sync_node_limit})
            begin
                st_next.sync_frame_overflow_flag = 1'b1;
            end
            st_next.count = '0;
            // Even set survives into the odd cycle that it gates
            if (cycle_odd_in)
            begin
                st_next.even_n = '0;
            end
        end
        unique case (st_reg.mst)
            sfcc_pkg::SFCC_IDLE:
            begin
            end
            sfcc_pkg::SFCC_SEL:
            begin
                // Drop extremes when more than two senders (see RULE11)
                if (st_reg.odd_n > (AW+1)'(2))
                begin
                    st_next.off = (st_reg.min2_dev + st_reg.max2_dev) >>> 1;
                end
                else
                begin
                    st_next.off = (st_reg.min_dev + st_reg.max_dev) >>> 1;
                end
                st_next.rate = st_reg.rate_acc >>> 2;
                st_next.mst = sfcc_pkg::SFCC_DONE;
            end
            sfcc_pkg::SFCC_DONE:
            begin
                st_next.corr_v = 1'b1;
                st_next.odd_n = '0;
                st_next.rate_acc = '0;
                st_next.min_dev = {1'b0, {(DW-1){1'b1}}};
                st_next.min2_dev = {1'b0, {(DW-1){1'b1}}};
                st_next.max_dev = {1'b1, {(DW-1){1'b0}}};
                st_next.max2_dev = {1'b1, {(DW-1){1'b0}}};
                st_next.mst = sfcc_pkg::SFCC_IDLE;
            end
            default:
            begin
                st_next.mst = sfcc_pkg::SFCC_IDLE;
            end
        endcase

        // Register access
        st_next.rdata = sfcc_pkg::UNMAPPED_DATA;
        if (wb_req && !wb_we_in)
        begin
            if (wb_adr_in == sfcc_pkg::TEST_ONE_OFS)
            begin
                st_next.rdata = {24'h0, code_b, code_a}; // see RULE1
            end
            else if (wb_adr_in == sfcc_pkg::ERR_FLAG_OFS)
            begin
                st_next.rdata = {31'h0, st_reg.sync_frame_overflow_flag};
            end
            else if (wb_adr_in == sfcc_pkg::TIMING_TWO_OFS)
            begin
                st_next.rdata = {28'h0, st_reg.sync_node_limit};
            end
            else if (wb_adr_in == sfcc_pkg::TIMING_FIVE_OFS)
            begin
                st_next.rdata = {st_reg.dcb, st_reg.dca};
            end
            else if (wb_adr_in == sfcc_pkg::CORR_OFS)
            begin
                st_next.rdata = {st_reg.rate, st_reg.off};
            end
            else if (wb_adr_in == sfcc_pkg::COUNT_OFS)
            begin
                st_next.rdata = {22'h0, st_reg.odd_n, st_reg.even_n};
            end
        end
        if (wb_req && wb_we_in)
        begin
            if (wb_adr_in == sfcc_pkg::ERR_FLAG_OFS && wb_sel_in[0]
                && wb_dat_in[0])
            begin
                st_next.sync_frame_overflow_flag = 1'b0; // Write one clears
            end
            else if (wb_adr_in == sfcc_pkg::TIMING_TWO_OFS && wb_sel_in[0])
            begin
                st_next.sync_node_limit = wb_dat_in[3:0];
            end
            else if (wb_adr_in == sfcc_pkg::TIMING_FIVE_OFS)
            begin
                if (&wb_sel_in[1:0])
                begin
                    st_next.dca = wb_dat_in[DW-1:0];
                end
                if (&wb_sel_in[3:2])
                begin
                    st_next.dcb = wb_dat_in[sfcc_pkg::DCB_LSB +: DW];
                end
            end
        end
        // Overflow set beats a clear in the same cycle (see RULE6)
        if (cycle_start_in
            && (st_reg.count + 5'(sync_node_in && own_sync_tx_in))
            > {1'b0, st_reg.sync_node_limit})
        begin
            st_next.sync_frame_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_reg <= '0;
            st_reg.sync_node_limit <= sfcc_pkg::SNM_RESET;
            st_reg.pend_ok <= 1'b1;
            st_reg.mst <= sfcc_pkg::SFCC_IDLE;
            st_reg.min_dev <= {1'b0, {(DW-1){1'b1}}};
            st_reg.min2_dev <= {1'b0, {(DW-1){1'b1}}};
            st_reg.max_dev <= {1'b1, {(DW-1){1'b0}}};
            st_reg.max2_dev <= {1'b1, {(DW-1){1'b0}}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Lists read back through registered memory outputs
    logic list_sel_even;
    logic list_sel_odd;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            list_sel_even <= 1'b0;
            list_sel_odd <= 1'b0;
        end
        else
        begin
            list_sel_even <= wb_req && !wb_we_in
                && wb_adr_in[7:6] == sfcc_pkg::EVEN_LIST_OFS[7:6];
            list_sel_odd <= wb_req && !wb_we_in
                && wb_adr_in[7:6] == sfcc_pkg::ODD_LIST_OFS[7:6];
        end
    end

    assign wb_ack_out = st_reg.ack;
    assign wb_dat_out = list_sel_even ? {21'h0, even_rd}
        : list_sel_odd ? {21'h0, odd_rd} : st_reg.rdata;
    assign offset_corr_out = st_reg.off;
    assign rate_corr_out = st_reg.rate;
    assign corr_valid_out = st_reg.corr_v;
endmodule

// file: verification/sfcc_monitor.sv
// Port checker for the sync frame correction block
// Assumes one clock domain; bound to the top module by name
`timescale 1ns/1ps
module sfcc_monitor #(
    parameter int MAX_SYNC = sfcc_pkg::MAX_SYNC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic cycle_start_in,
    input wire logic signed [15:0] offset_corr_out,
    input wire logic signed [15:0] rate_corr_out,
    input wire logic corr_valid_out
);
    // ==========================================================
    // Sequences
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence wb_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence ack_seen;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    sequence corr_launch;
        cycle_start_in ##3 corr_valid_out;
    endsequence

    // ==========================================================
    // Assertions
    ack_follows_a: assert property (wb_take |=> ack_seen)
        else $error("ack missing after request");
    ack_cause_a: assert property ($rose(wb_ack_out) |->
        $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_out && !wb_we_in &&
        wb_adr_in >= 8'h18 && wb_adr_in <= 8'h3c |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    corr_timing_a: assert property (cycle_start_in |-> corr_launch)
        else $error("correction result late");
    corr_cause_a: assert property (corr_valid_out |->
        $past(cycle_start_in, 3)) else $error("stray correction pulse");
    offset_hold_a: assert property ($changed(offset_corr_out) |=>
        corr_valid_out) else $error("offset moved unannounced");
    rate_hold_a: assert property ($changed(rate_corr_out) |=>
        corr_valid_out) else $error("rate moved unannounced");
    ack_single_a: assert property (wb_ack_out |-> ##1 !wb_ack_out)
        else $error("ack longer than one cycle");
endmodule

bind sfcc_top sfcc_monitor #(.MAX_SYNC(MAX_SYNC)) i_mon (
    .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .cycle_start_in(cycle_start_in), .offset_corr_out(offset_corr_out),
    .rate_corr_out(rate_corr_out), .corr_valid_out(corr_valid_out)
);

// file: verification/sfcc_peer.sv
// Model of the other bus nodes: frame measurements and slot timing
// Assumes its tasks are called from the bench, one at a time
`timescale 1ns/1ps
module sfcc_peer (
    input wire logic clk_in,
    output sfcc_pkg::sfcc_meas_type meas_a_out,
    output sfcc_pkg::sfcc_meas_type meas_b_out,
    output logic slot_boundary_out
);
    // ==========================================================
    // Frame strobes
    initial
    begin
        meas_a_out = '0;
        meas_b_out = '0;
        slot_boundary_out = 1'b0;
    end

    // Sync frames go out on both channels, few senders
    // Idle fields inverted so a stale value never looks valid
    task frame(input logic [10:0] id, input logic sync,
        input logic [15:0] da, input logic [15:0] db, input logic bnd);
        begin
            @(posedge clk_in);
            meas_a_out <= '{1'b1, sync, id, da};
            meas_b_out <= '{1'b1, sync, id, db};
            slot_boundary_out <= bnd;
            @(posedge clk_in);
            meas_a_out <= '{1'b0, ~sync, ~id, ~da};
            meas_b_out <= '{1'b0, ~sync, ~id, ~db};
            slot_boundary_out <= 1'b0;
        end
    endtask

    // Noise: a time reference seen without a valid frame
    task noise(input logic [15:0] d);
        begin
            @(posedge clk_in);
            meas_a_out <= '{1'b0, 1'b1, 11'h7ff, d};
            meas_b_out <= '{1'b0, 1'b1, 11'h7ff, d};
            @(posedge clk_in);
            meas_a_out <= '0;
            meas_b_out <= '0;
        end
    endtask

    task slot;
        begin
            @(posedge clk_in);
            slot_boundary_out <= 1'b1;
            @(posedge clk_in);
            slot_boundary_out <= 1'b0;
        end
    endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench: Wishbone register access and cycle scenarios
// Assumes the design package and the peer model are compiled first
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic a_tgl = 1'b0;
    logic b_tgl = 1'b0;
    logic [3:0] a_code = 4'h0;
    logic [3:0] b_code = 4'h0;
    logic cycle_start = 1'b0;
    logic cycle_odd = 1'b0;
    logic own_tx = 1'b0;
    logic bnd;
    logic signed [15:0] ofs;
    logic signed [15:0] rate;
    logic cv;
    sfcc_pkg::sfcc_meas_type ma;
    sfcc_pkg::sfcc_meas_type mb;
    int errors = 0;
    int num_checks = 0;

    always #25 clk_in = ~clk_in;

    sfcc_peer i_peer (.clk_in(clk_in), .meas_a_out(ma), .meas_b_out(mb),
        .slot_boundary_out(bnd));
    sfcc_top #(.MAX_SYNC(sfcc_pkg::MAX_SYNC)) i_dut (.clk_in(clk_in),
        .rst_in(rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hf),
        .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
        .chan_a_coding_error_code_toggle_in(a_tgl), .chan_a_coding_error_code_code_in(a_code),
        .chan_b_coding_error_code_toggle_in(b_tgl), .chan_b_coding_error_code_code_in(b_code),
        .cycle_start_in(cycle_start), .cycle_odd_in(cycle_odd),
        .slot_boundary_in(bnd), .sync_node_in(1'b1),
        .own_sync_tx_in(own_tx), .meas_a_in(ma), .meas_b_in(mb),
        .offset_corr_out(ofs), .rate_corr_out(rate), .corr_valid_out(cv));

    // ==========================================================
    // Tasks
    task give_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        begin
            num_checks++;
            if (g !== e)
            begin
                errors++;
                $display("wrong value %s expected %h seen %h", name, e, g);
            end
        end
    endtask

    // Bounded wait on ack; a hang ends the run
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        begin
            @(posedge clk_in);
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we <= w;
            wb_adr <= a;
            wb_dat <= d;
            @(posedge clk_in);
            n = 1;
            while (wb_ack !== 1'b1 && n < 50)
            begin
                @(posedge clk_in);
                n++;
            end
            if (wb_ack !== 1'b1)
            begin
                errors++;
                give_verdict;
            end
            q = wb_rdat;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        begin
            wb(1'b0, a, 32'h0, q);
            chk(nm, e, q);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        begin
            wb(1'b1, a, d, q);
        end
    endtask

    task code(input logic b, input logic [3:0] c);
        begin
            @(posedge clk_in);
            if (b)
                b_code <= c;
            else
                a_code <= c;
            @(posedge clk_in);
            if (b)
                b_tgl <= ~b_tgl;
            else
                a_tgl <= ~a_tgl;
            repeat (6) @(posedge clk_in);
        end
    endtask

    // Close a cycle; parity held through the start pulse
    task end_cycle(input logic nxt, input logic [15:0] e, input logic on);
        int n;
        begin
            @(posedge clk_in);
            cycle_start <= 1'b1;
            @(posedge clk_in);
            cycle_start <= 1'b0;
            cycle_odd <= nxt;
            n = 0;
            while (cv !== 1'b1 && n < 10)
            begin
                @(negedge clk_in);
                n++;
            end
            if (n >= 10)
            begin
                errors++;
                give_verdict;
            end
            if (on)
                chk("offset", {16'h0, e}, {16'h0, ofs});
        end
    endtask

    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(sfcc_pkg::TEST_ONE_OFS, 32'h0, "codes");
        rd(sfcc_pkg::ERR_FLAG_OFS, 32'h0, "overflow");
        rd(sfcc_pkg::TIMING_TWO_OFS, 32'hf, "limit");
        rd(8'h18, 32'h0, "unmapped");
        code(1'b0, 4'h5);
        rd(sfcc_pkg::TEST_ONE_OFS, 32'h05, "codes");
        code(1'b1, 4'ha);
        rd(sfcc_pkg::TEST_ONE_OFS, 32'ha5, "codes");
        wr(sfcc_pkg::TIMING_TWO_OFS, 32'h2);
        wr(sfcc_pkg::TIMING_FIVE_OFS, 32'h0);
        own_tx <= 1'b1;
        // Even cycle reaches the limit; own frame pushes it over
        i_peer.frame(11'd1, 1'b1, 16'd10, 16'd10, 1'b1);
        i_peer.frame(11'd2, 1'b1, 16'd20, 16'd20, 1'b1);
        end_cycle(1'b1, 16'h0, 1'b0);
        rd(sfcc_pkg::ERR_FLAG_OFS, 32'h1, "overflow");
        wr(sfcc_pkg::ERR_FLAG_OFS, 32'h1);
        rd(sfcc_pkg::ERR_FLAG_OFS, 32'h0, "overflow");
        rd(8'h40, 32'd1, "even list");
        rd(8'h44, 32'd2, "even list");
        // Odd cycle: stranger id 3 first, must be left out
        i_peer.frame(11'd3, 1'b1, 16'd100, 16'd100, 1'b1);
        i_peer.frame(11'd1, 1'b1, 16'd4, 16'd4, 1'b1);
        i_peer.frame(11'd2, 1'b1, 16'd6, 16'd6, 1'b1);
        end_cycle(1'b0, 16'd5, 1'b1);
        rd(8'h80, 32'd1, "odd list");
        rd(8'h84, 32'd2, "odd list");
        wr(sfcc_pkg::ERR_FLAG_OFS, 32'h1);
        // Count equal to limit with own frame: no overflow
        i_peer.frame(11'd1, 1'b1, 16'd0, 16'd0, 1'b1);
        end_cycle(1'b1, 16'h0, 1'b0);
        rd(sfcc_pkg::ERR_FLAG_OFS, 32'h0, "overflow");
        // Channel A compensated to negative; boundary frame, noise
        wr(sfcc_pkg::TIMING_FIVE_OFS, 32'h0000_0004);
        i_peer.frame(11'd9, 1'b0, 16'd50, 16'd50, 1'b1);
        i_peer.noise(16'd99);
        i_peer.frame(11'd1, 1'b1, 16'd3, 16'd1, 1'b0);
        end_cycle(1'b0, 16'hffff, 1'b1);
        give_verdict;
    end
endmodule
